// ==== oag_cfg.svh ====
`ifndef OAG_CFG_SVH
`define OAG_CFG_SVH

`define OAG_ADDR_W     16
`define OAG_DATA_W     8
`define OAG_ZERO_PAGE  8'h00
`define OAG_PORT_RST   8'h00
`define OAG_ADDR_RST   16'h0000
`define OAG_DATA_RST   8'h00
`define OAG_PTR_STEP   8'h01
`define OAG_ADDR_STEP  16'h0001
`define OAG_X_STEP     8'h01

`endif

// ==== oag_pkg.sv ====
package oag_pkg;

   typedef enum logic [4:0] {
      OAG_REG_A,
      OAG_REG_X,
      OAG_REG_Y,
      OAG_REG_C,
      OAG_REG_PSW,
      OAG_IMM,
      OAG_DP,
      OAG_ABS,
      OAG_ABS_RAM,
      OAG_DP_XINC,
      OAG_DP_X,
      OAG_DP_X_OFF,
      OAG_DP_Y_OFF,
      OAG_ABS_Y,
      OAG_DP_IND,
      OAG_DP_X_IND,
      OAG_DP_Y_IND,
      OAG_ABS_IND
   } oag_mode_t;

   typedef enum logic [2:0] {
      OAG_IDLE,
      OAG_RD_LO,
      OAG_RD_HI,
      OAG_FINISH
   } oag_state_t;

endpackage

// ==== oag_operand_address_generator.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "oag_cfg.svh"

// Contract
// - Register modes read A, X, Y, C, status
// - Immediate mode returns second byte as data
// - Page flag set: address is page register, operand
// - Direct-page mode addresses operand inside direct page
// - Absolute: second byte low, third byte high
// - Absolute RAM operations ignore flag and page register
// - Auto-increment: address by X, then X plus one
// - Indexed without offset uses X alone
// - Operand plus X, wrapped inside direct page
// - Operand plus Y, wrapped inside direct page
// - Absolute address plus Y reaches whole space
// - Direct-page indirect jump loads pointer pair
// - Operand plus X selects pointer, low first
// - Pointer at operand pair, then add Y
// - Absolute indirect jump loads stored 16-bit value
// - Port latch captures bus on write strobe
// - Register strobe returns latch, pin strobe returns pins
module oag_operand_address_generator (
   input  wire logic                      sys_clk,
   input  wire logic                      rstn,
   input  wire logic                      start,
   input  wire oag_pkg::oag_mode_t        mode,
   input  wire logic [`OAG_DATA_W-1:0]    operand_lo,
   input  wire logic [`OAG_DATA_W-1:0]    operand_hi,
   input  wire logic [`OAG_DATA_W-1:0]    acc,
   input  wire logic [`OAG_DATA_W-1:0]    x_reg,
   input  wire logic [`OAG_DATA_W-1:0]    y_reg,
   input  wire logic                      carry,
   input  wire logic [`OAG_DATA_W-1:0]    processor_status_word,
   input  wire logic                      page_flag,
   input  wire logic [`OAG_DATA_W-1:0]    ram_page_register,
   output logic                           busy,
   output logic                           done,
   output logic                           addr_valid,
   output logic [`OAG_ADDR_W-1:0]         eff_addr,
   output logic [`OAG_DATA_W-1:0]         operand_value,
   output logic                           x_wr,
   output logic [`OAG_DATA_W-1:0]         x_next,
   output logic                           pc_load,
   output logic [`OAG_ADDR_W-1:0]         pc_target,
   output logic                           mem_req,
   output logic [`OAG_ADDR_W-1:0]         mem_addr,
   input  wire logic                      mem_ack,
   input  wire logic [`OAG_DATA_W-1:0]    mem_rdata,
   input  wire logic                      port_wr,
   input  wire logic [`OAG_DATA_W-1:0]    port_wdata,
   input  wire logic                      port_rd_reg,
   input  wire logic                      port_rd_pin,
   input  wire logic [`OAG_DATA_W-1:0]    port_pins,
   output logic [`OAG_DATA_W-1:0]         port_latch,
   output logic [`OAG_DATA_W-1:0]         port_rdata,
   output logic                           port_rvalid
);

   oag_pkg::oag_state_t         state;
   oag_pkg::oag_mode_t          cur_mode;
   logic [`OAG_DATA_W-1:0]      dp_page;
   logic [`OAG_DATA_W-1:0]      ptr_lo;
   logic [`OAG_DATA_W-1:0]      ptr_hi;
   logic [`OAG_DATA_W-1:0]      lat_y;
   logic [`OAG_ADDR_W-1:0]      ptr_addr;
   logic [`OAG_ADDR_W-1:0]      next_ptr_addr;
   logic [`OAG_ADDR_W-1:0]      next_addr;
   logic [`OAG_DATA_W-1:0]      next_value;
   logic                        next_is_addr;
   logic                        is_ind;
   logic [`OAG_ADDR_W-1:0]      ptr_word;

   // Direct page follows the page flag, page zero otherwise
   always_comb begin
      dp_page = page_flag ? ram_page_register : `OAG_ZERO_PAGE;
   end

   // Indirect modes need two pointer byte reads
   assign is_ind = (mode == oag_pkg::OAG_DP_IND) || (mode == oag_pkg::OAG_DP_X_IND)
                || (mode == oag_pkg::OAG_DP_Y_IND) || (mode == oag_pkg::OAG_ABS_IND);

   // Register and immediate modes carry data, not an address
   always_comb begin
      next_addr     = `OAG_ADDR_RST;
      next_value    = `OAG_DATA_RST;
      next_is_addr  = 1'b1;
      next_ptr_addr = `OAG_ADDR_RST;
      unique case (mode)
         oag_pkg::OAG_REG_A: begin
            next_value   = acc;
            next_is_addr = 1'b0;
         end
         oag_pkg::OAG_REG_X: begin
            next_value   = x_reg;
            next_is_addr = 1'b0;
         end
         oag_pkg::OAG_REG_Y: begin
            next_value   = y_reg;
            next_is_addr = 1'b0;
         end
         oag_pkg::OAG_REG_C: begin
            next_value   = {{(`OAG_DATA_W-1){1'b0}}, carry};
            next_is_addr = 1'b0;
         end
         oag_pkg::OAG_REG_PSW: begin
            next_value   = processor_status_word;
            next_is_addr = 1'b0;
         end
         oag_pkg::OAG_IMM: begin
            next_value   = operand_lo;
            next_is_addr = 1'b0;
         end
         oag_pkg::OAG_DP:
            next_addr = {dp_page, operand_lo};
         oag_pkg::OAG_ABS:
            next_addr = {operand_hi, operand_lo};
         oag_pkg::OAG_ABS_RAM:
            next_addr = {operand_hi, operand_lo};
         oag_pkg::OAG_DP_XINC:
            next_addr = {dp_page, x_reg};
         oag_pkg::OAG_DP_X:
            next_addr = {dp_page, x_reg};
         oag_pkg::OAG_DP_X_OFF:
            next_addr = {dp_page, operand_lo + x_reg};
         oag_pkg::OAG_DP_Y_OFF:
            next_addr = {dp_page, operand_lo + y_reg};
         oag_pkg::OAG_ABS_Y:
            next_addr = {operand_hi, operand_lo} + {{`OAG_DATA_W{1'b0}}, y_reg};
         oag_pkg::OAG_DP_IND:
            next_ptr_addr = {dp_page, operand_lo};
         oag_pkg::OAG_DP_X_IND:
            next_ptr_addr = {dp_page, operand_lo + x_reg};
         oag_pkg::OAG_DP_Y_IND:
            next_ptr_addr = {dp_page, operand_lo};
         oag_pkg::OAG_ABS_IND:
            next_ptr_addr = {operand_hi, operand_lo};
         default: begin
            // Unknown codes answer as data zero
            next_is_addr = 1'b0;
         end
      endcase
   end

   assign ptr_word = {ptr_hi, ptr_lo};

   // Sequencer for pointer fetches
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         state <= oag_pkg::OAG_IDLE;
      end else begin
         unique case (state)
            oag_pkg::OAG_IDLE: begin
               if (start && is_ind) begin
                  state <= oag_pkg::OAG_RD_LO;
               end
            end
            oag_pkg::OAG_RD_LO: begin
               if (mem_ack) begin
                  state <= oag_pkg::OAG_RD_HI;
               end
            end
            oag_pkg::OAG_RD_HI: begin
               if (mem_ack) begin
                  state <= oag_pkg::OAG_FINISH;
               end
            end
            oag_pkg::OAG_FINISH: begin
               state <= oag_pkg::OAG_IDLE;
            end
            default: begin
               // Illegal state codes fall back to idle
               state <= oag_pkg::OAG_IDLE;
            end
         endcase
      end
   end

   // Request latch
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         cur_mode <= oag_pkg::OAG_REG_A;
         ptr_addr <= `OAG_ADDR_RST;
         lat_y    <= `OAG_DATA_RST;
      end else if (state == oag_pkg::OAG_IDLE && start) begin
         cur_mode <= mode;
         ptr_addr <= next_ptr_addr;
         lat_y    <= y_reg;
      end
   end

   // Pointer pair reads, low byte first
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         ptr_lo <= `OAG_DATA_RST;
         ptr_hi <= `OAG_DATA_RST;
      end else begin
         if (state == oag_pkg::OAG_RD_LO && mem_ack) begin
            ptr_lo <= mem_rdata;
         end
         if (state == oag_pkg::OAG_RD_HI && mem_ack) begin
            ptr_hi <= mem_rdata;
         end
      end
   end

   // Read request stands while a pointer byte is outstanding
   assign mem_req = (state == oag_pkg::OAG_RD_LO) || (state == oag_pkg::OAG_RD_HI);

   // Pointer byte address, registered so the bus sees no adder output
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         mem_addr <= `OAG_ADDR_RST;
      end else if (state == oag_pkg::OAG_IDLE && start) begin
         mem_addr <= next_ptr_addr;
      end else if (state == oag_pkg::OAG_RD_LO && mem_ack) begin
         // Direct-page pairs wrap inside the page, absolute pairs carry
         if (cur_mode == oag_pkg::OAG_ABS_IND) begin
            mem_addr <= ptr_addr + `OAG_ADDR_STEP;
         end else begin
            mem_addr <= {ptr_addr[15:8], ptr_addr[7:0] + `OAG_PTR_STEP};
         end
      end
   end

   // Busy refuses new starts during pointer fetch and finish
   assign busy = (state != oag_pkg::OAG_IDLE);

   // Result outputs
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         done          <= 1'b0;
         addr_valid    <= 1'b0;
         eff_addr      <= `OAG_ADDR_RST;
         operand_value <= `OAG_DATA_RST;
         pc_load       <= 1'b0;
         pc_target     <= `OAG_ADDR_RST;
      end else begin
         done    <= 1'b0;
         pc_load <= 1'b0;
         if (state == oag_pkg::OAG_IDLE && start && !is_ind) begin
            done          <= 1'b1;
            addr_valid    <= next_is_addr;
            eff_addr      <= next_addr;
            operand_value <= next_value;
         end else if (state == oag_pkg::OAG_FINISH) begin
            done <= 1'b1;
            // Jumps load the program counter, data modes publish an address
            if (cur_mode == oag_pkg::OAG_DP_IND || cur_mode == oag_pkg::OAG_ABS_IND) begin
               pc_load    <= 1'b1;
               pc_target  <= ptr_word;
               addr_valid <= 1'b0;
            end else if (cur_mode == oag_pkg::OAG_DP_Y_IND) begin
               addr_valid <= 1'b1;
               eff_addr   <= ptr_word + {{`OAG_DATA_W{1'b0}}, lat_y};
            end else begin
               addr_valid <= 1'b1;
               eff_addr   <= ptr_word;
            end
         end
      end
   end

   // Post-increment of X
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         x_wr   <= 1'b0;
         x_next <= `OAG_DATA_RST;
      end else begin
         x_wr <= 1'b0;
         if (state == oag_pkg::OAG_IDLE && start && mode == oag_pkg::OAG_DP_XINC) begin
            x_wr   <= 1'b1;
            x_next <= x_reg + `OAG_X_STEP;
         end
      end
   end

   // Port data latch
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         port_latch <= `OAG_PORT_RST;
      end else if (port_wr) begin
         port_latch <= port_wdata;
      end
   end

   // Port read path
   // Pin strobe wins when both strobes arrive together
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         port_rdata  <= `OAG_DATA_RST;
         port_rvalid <= 1'b0;
      end else begin
         port_rvalid <= port_rd_reg || port_rd_pin;
         if (port_rd_pin) begin
            port_rdata <= port_pins;
         end else if (port_rd_reg) begin
            port_rdata <= port_latch;
         end
      end
   end

endmodule
`default_nettype wire

// ==== oag_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module oag_chk (
   input wire logic               sys_clk,
   input wire logic               rstn,
   input wire logic               start,
   input wire oag_pkg::oag_mode_t mode,
   input wire logic [7:0]         operand_lo,
   input wire logic [7:0]         operand_hi,
   input wire logic [7:0]         x_reg,
   input wire logic [7:0]         y_reg,
   input wire logic               page_flag,
   input wire logic [7:0]         ram_page_register,
   input wire logic               busy,
   input wire logic               done,
   input wire logic               addr_valid,
   input wire logic [15:0]        eff_addr,
   input wire logic [7:0]         operand_value,
   input wire logic               x_wr,
   input wire logic [7:0]         x_next,
   input wire logic               port_wr,
   input wire logic [7:0]         port_wdata,
   input wire logic               port_rd_pin,
   input wire logic [7:0]         port_pins,
   input wire logic [7:0]         port_latch,
   input wire logic [7:0]         port_rdata,
   input wire logic               port_rvalid
);
   logic [7:0] dph;
   logic       go;
   // Direct page high byte as seen at the start edge
   always_ff @(posedge sys_clk) dph <= page_flag ? ram_page_register : 8'h00;
   assign go = start && !busy;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   property p_dp;
      go && mode == oag_pkg::OAG_DP |=> done && eff_addr == {dph, $past(operand_lo)};
   endproperty
   a_dp: assert property (p_dp) else $error("direct page address wrong");
   property p_absram;
      go && mode == oag_pkg::OAG_ABS_RAM |=> eff_addr == $past({operand_hi, operand_lo});
   endproperty
   a_absram: assert property (p_absram) else $error("absolute address wrong");
   property p_imm;
      go && mode == oag_pkg::OAG_IMM |=> !addr_valid && operand_value == $past(operand_lo);
   endproperty
   a_imm: assert property (p_imm) else $error("immediate value wrong");
   property p_xinc;
      go && mode == oag_pkg::OAG_DP_XINC |=> x_wr && x_next == $past(x_reg) + 8'h01;
   endproperty
   a_xinc: assert property (p_xinc) else $error("index increment wrong");
   property p_dpx;
      go && mode == oag_pkg::OAG_DP_X_OFF |=> eff_addr == {dph, $past(operand_lo + x_reg)};
   endproperty
   a_dpx: assert property (p_dpx) else $error("x offset address wrong");
   property p_dpy;
      go && mode == oag_pkg::OAG_DP_Y_OFF |=> eff_addr == {dph, $past(operand_lo + y_reg)};
   endproperty
   a_dpy: assert property (p_dpy) else $error("y offset address wrong");
   property p_absy;
      go && mode == oag_pkg::OAG_ABS_Y |=>
         eff_addr == $past({operand_hi, operand_lo} + {8'h00, y_reg});
   endproperty
   a_absy: assert property (p_absy) else $error("absolute y address wrong");
   property p_latch;
      port_wr |=> port_latch == $past(port_wdata);
   endproperty
   a_latch: assert property (p_latch) else $error("port latch missed write");
   property p_pin;
      port_rd_pin |=> port_rvalid && port_rdata == $past(port_pins);
   endproperty
   a_pin: assert property (p_pin) else $error("pin read wrong");
   c_xw: cover property (x_wr);
   c_pin: cover property (port_rd_pin ##1 port_rvalid);
   c_ind: cover property (busy ##1 done);
endmodule
bind oag_operand_address_generator oag_chk u_chk (
   .sys_clk           (sys_clk),
   .rstn              (rstn),
   .start             (start),
   .mode              (mode),
   .operand_lo        (operand_lo),
   .operand_hi        (operand_hi),
   .x_reg             (x_reg),
   .y_reg             (y_reg),
   .page_flag         (page_flag),
   .ram_page_register (ram_page_register),
   .busy              (busy),
   .done              (done),
   .addr_valid        (addr_valid),
   .eff_addr          (eff_addr),
   .operand_value     (operand_value),
   .x_wr              (x_wr),
   .x_next            (x_next),
   .port_wr           (port_wr),
   .port_wdata        (port_wdata),
   .port_rd_pin       (port_rd_pin),
   .port_pins         (port_pins),
   .port_latch        (port_latch),
   .port_rdata        (port_rdata),
   .port_rvalid       (port_rvalid)
);
`default_nettype wire

// ==== oag_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module oag_mem_model (
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   input  wire logic        mem_req,
   input  wire logic [15:0] mem_addr,
   input  wire logic [1:0]  wait_cyc,
   output logic             mem_ack,
   output logic [7:0]       mem_rdata
);
   logic [1:0] cnt;
   logic [7:0] val;
   // Wait states restart after every answered byte
   always_ff @(posedge sys_clk) begin
      if (!rstn || !mem_req || mem_ack) begin
         cnt <= 2'h0;
      end else begin
         cnt <= cnt + 2'h1;
      end
   end
   assign val       = mem_addr[7:0] ^ mem_addr[15:8] ^ 8'hA5;
   assign mem_ack   = mem_req && (cnt == wait_cyc);
   // Outside an answer the bus shows the inverse, never a stale byte
   assign mem_rdata = mem_ack ? val : ~val;
endmodule
`default_nettype wire

// ==== test_operand_address_generator.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_operand_address_generator;
   logic sys_clk = 1'b0, rstn = 1'b0, start = 1'b0, carry = 1'b1, page_flag = 1'b0;
   logic port_wr = 1'b0, port_rd_reg = 1'b0, port_rd_pin = 1'b0;
   oag_pkg::oag_mode_t mode = oag_pkg::OAG_REG_A;
   logic [7:0] operand_lo = 8'h00, operand_hi = 8'h00, acc = 8'h11, x_reg = 8'h22;
   logic [7:0] y_reg = 8'h33, processor_status_word = 8'h44, ram_page_register = 8'h07;
   logic [7:0] port_wdata = 8'h00, port_pins = 8'h00;
   logic [1:0] wait_cyc = 2'h0;
   logic busy, done, addr_valid, x_wr, pc_load, mem_req, mem_ack, port_rvalid;
   logic [15:0] eff_addr, pc_target, mem_addr;
   logic [7:0] operand_value, x_next, mem_rdata, port_latch, port_rdata;
   int miscompares = 0, cmp_count = 0;
   always #4 sys_clk = ~sys_clk;
   oag_operand_address_generator DUT (
      .sys_clk               (sys_clk),
      .rstn                  (rstn),
      .start                 (start),
      .mode                  (mode),
      .operand_lo            (operand_lo),
      .operand_hi            (operand_hi),
      .acc                   (acc),
      .x_reg                 (x_reg),
      .y_reg                 (y_reg),
      .carry                 (carry),
      .processor_status_word (processor_status_word),
      .page_flag             (page_flag),
      .ram_page_register     (ram_page_register),
      .busy                  (busy),
      .done                  (done),
      .addr_valid            (addr_valid),
      .eff_addr              (eff_addr),
      .operand_value         (operand_value),
      .x_wr                  (x_wr),
      .x_next                (x_next),
      .pc_load               (pc_load),
      .pc_target             (pc_target),
      .mem_req               (mem_req),
      .mem_addr              (mem_addr),
      .mem_ack               (mem_ack),
      .mem_rdata             (mem_rdata),
      .port_wr               (port_wr),
      .port_wdata            (port_wdata),
      .port_rd_reg           (port_rd_reg),
      .port_rd_pin           (port_rd_pin),
      .port_pins             (port_pins),
      .port_latch            (port_latch),
      .port_rdata            (port_rdata),
      .port_rvalid           (port_rvalid)
   );
   oag_mem_model MEM (
      .sys_clk   (sys_clk),
      .rstn      (rstn),
      .mem_req   (mem_req),
      .mem_addr  (mem_addr),
      .wait_cyc  (wait_cyc),
      .mem_ack   (mem_ack),
      .mem_rdata (mem_rdata)
   );
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   function automatic logic [7:0] mv(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'hA5;
   endfunction
   task automatic run(input oag_pkg::oag_mode_t m, input logic [7:0] l, input logic [7:0] h);
      int n;
      mode = m;
      operand_lo = l;
      operand_hi = h;
      start = 1'b1;
      @(negedge sys_clk);
      start = 1'b0;
      chk(busy, m >= oag_pkg::OAG_DP_IND);
      for (n = 0; n < 20 && done !== 1'b1; n++) @(negedge sys_clk);
      chk(done, 1'b1);
   endtask
   task automatic t_reg;
      logic [7:0] e[5];
      e = '{acc, x_reg, y_reg, {7'h00, carry}, processor_status_word};
      for (int i = 0; i < 5; i++) begin
         run(oag_pkg::oag_mode_t'(i), 8'hEE, 8'h00);
         chk(operand_value, e[i]);
      end
   endtask
   task automatic t_dp;
      run(oag_pkg::OAG_IMM, 8'h35, 8'h00);
      chk({operand_value, 7'h00, addr_valid}, 16'h3500);
      run(oag_pkg::OAG_DP, 8'h35, 8'h00);
      chk(eff_addr, 16'h0035);
      page_flag = 1'b1;
      run(oag_pkg::OAG_DP, 8'h35, 8'h00);
      chk(eff_addr, 16'h0735);
      run(oag_pkg::OAG_ABS_RAM, 8'h15, 8'h01);
      chk(eff_addr, 16'h0115);
      run(oag_pkg::OAG_ABS, 8'h35, 8'hF0);
      chk(eff_addr, 16'hF035);
      x_reg = 8'h15;
      run(oag_pkg::OAG_DP_X, 8'h00, 8'h00);
      chk(eff_addr, 16'h0715);
      page_flag = 1'b0;
   endtask
   task automatic t_idx;
      x_reg = 8'h35;
      run(oag_pkg::OAG_DP_XINC, 8'h00, 8'h00);
      chk({eff_addr[7:0], x_next}, 16'h3536);
      chk(x_wr, 1'b1);
      x_reg = 8'hF5;
      run(oag_pkg::OAG_DP_X_OFF, 8'h45, 8'h00);
      chk(eff_addr, 16'h003A);
      y_reg = 8'hF0;
      run(oag_pkg::OAG_DP_Y_OFF, 8'h20, 8'h00);
      chk(eff_addr, 16'h0010);
      y_reg = 8'h55;
      run(oag_pkg::OAG_ABS_Y, 8'h00, 8'hFA);
      chk(eff_addr, 16'hFA55);
   endtask
   task automatic t_ind;
      run(oag_pkg::OAG_DP_IND, 8'h35, 8'h00);
      chk({pc_load, 7'h00, addr_valid}, 16'h0100);
      chk(pc_target, {mv(16'h0036), mv(16'h0035)});
      wait_cyc = 2'h2;
      x_reg = 8'h10;
      run(oag_pkg::OAG_DP_X_IND, 8'h25, 8'h00);
      chk(eff_addr, {mv(16'h0036), mv(16'h0035)});
      y_reg = 8'h10;
      run(oag_pkg::OAG_DP_Y_IND, 8'hFF, 8'h00);
      chk(eff_addr, {mv(16'h0000), mv(16'h00FF)} + 16'h0010);
      run(oag_pkg::OAG_ABS_IND, 8'h25, 8'hE0);
      chk(pc_target, {mv(16'hE026), mv(16'hE025)});
      wait_cyc = 2'h0;
   endtask
   task automatic t_port;
      port_wdata = 8'hA5;
      port_wr = 1'b1;
      port_rd_reg = 1'b1;
      @(negedge sys_clk);
      port_wr = 1'b0;
      chk({port_rdata, port_latch}, 16'h00A5);
      port_pins = 8'h3C;
      @(negedge sys_clk);
      chk({port_rdata, 7'h00, port_rvalid}, 16'hA501);
      port_rd_pin = 1'b1;
      @(negedge sys_clk);
      port_rd_pin = 1'b0;
      port_rd_reg = 1'b0;
      chk(port_rdata, 8'h3C);
   endtask
   task automatic tally_and_finish;
      $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (3) @(negedge sys_clk);
      rstn = 1'b1;
      t_reg;
      t_dp;
      t_idx;
      t_ind;
      t_port;
      tally_and_finish;
   end
   initial begin
      #24000;
      miscompares++;
      tally_and_finish;
   end
endmodule
`default_nettype wire
